// >>> shared/ahrb_pkg.sv
/*
  ahrb_pkg: register map, field positions, reset values and shared types of the
  parallel disk interface register block.
  assumes: one 25 MHz clock; register indices are word indices, byte address = 4 * index.
*/
package ahrb_pkg;
  // clock period in ns; every timing register counts whole periods of it
  localparam int CLK_PERIOD_NS = 40;

  // register indices (byte address = index * 4)
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int TIMING_COUNT = 24;
  localparam logic [IDX_W-1:0] IDX_TIMING_FIRST = 6'h00;
  localparam logic [IDX_W-1:0] IDX_TIMING_LAST = 6'h17;
  localparam logic [IDX_W-1:0] IDX_FIFO_WORD = 6'h18;
  localparam logic [IDX_W-1:0] IDX_FIFO_HALF = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_FIFO_FILL = 6'h20;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h24;
  localparam logic [IDX_W-1:0] IDX_ALARM = 6'h30;

  // interface_control bit positions
  localparam int CTL_FIFO_RESET_N = 7;
  localparam int CTL_DRIVE_RESET_N = 6;
  localparam int CTL_FIFO_TX_DMA_ENABLE = 5;
  localparam int CTL_FIFO_RX_DMA_ENABLE = 4;
  localparam int CTL_DRIVE_BURST_ACCEPT = 3;
  localparam int CTL_BURST_PROTOCOL_SELECT = 2;
  localparam int CTL_BURST_DIRECTION_OUT = 1;
  localparam int CTL_PIO_READY_WAIT_ENABLE = 0;

  // reset values
  localparam logic [7:0] TIMING_RST = 8'h01;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ALARM_RST = 8'h10;
  localparam int FIFO_DEPTH_DEF = 64;

  // timing register slots used by each bus phase
  localparam int TP_PIO_SETUP = 2;
  localparam int TP_PIO_WRITE = 3;
  localparam int TP_PIO_READ = 4;
  localparam int TP_PIO_RECOVER = 7;
  localparam int TP_MDMA_SETUP = 9;
  localparam int TP_MDMA_ACTIVE = 11;
  localparam int TP_MDMA_RECOVER = 12;
  localparam int TP_UDMA_SETUP = 14;
  localparam int TP_UDMA_RECOVER = 22;
  localparam int TP_UDMA_ACTIVE = 23;

  // bus phase selectors
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_ACTIVE = 2'h1;
  localparam logic [1:0] PH_RECOVER = 2'h2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [TIMING_COUNT-1:0][7:0] ahrb_timing_t;
endpackage

// >>> shared/ahrb_fifo_if.sv
/*
  ahrb_fifo_if: push, pop and status lines between the register block and its halfword fifo.
  assumes: one clock; at most two halfwords pushed and two popped per cycle.
*/
`timescale 1ns/100ps
interface ahrb_fifo_if;
  logic [1:0] push_n;
  logic [1:0][15:0] push_data;
  logic [1:0] pop_n;
  logic [1:0][15:0] head;
  logic [7:0] level;
  logic [7:0] space;
  modport store (input push_n, input push_data, input pop_n,
                 output head, output level, output space);
  modport user (output push_n, output push_data, output pop_n,
                input head, input level, input space);
endinterface

// >>> hw/ahrb_fifo.sv
/*
  ahrb_fifo: halfword fifo, entry 0 of a push or pop is the older one.
  assumes: the user never pushes beyond space or pops beyond level; depth a power of two
  and at most 128 so the level fits eight bits.
*/
`timescale 1ns/100ps
module ahrb_fifo
  import ahrb_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fifo_rst_n,
  // fifo port
  ahrb_fifo_if.store fif
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [7:0] level;
  } ahrb_fifo_st_t;

  ahrb_fifo_st_t st_r;
  ahrb_fifo_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (fif.push_n != 2'h0)
      st_nxt.mem[st_r.wp] = fif.push_data[0];
    if (fif.push_n == 2'h2)
      st_nxt.mem[st_r.wp + AW'(1)] = fif.push_data[1];
    st_nxt.wp = st_r.wp + AW'(fif.push_n);
    st_nxt.rp = st_r.rp + AW'(fif.pop_n);
    st_nxt.level = st_r.level + 8'(fif.push_n) - 8'(fif.pop_n);
    fif.head[0] = st_r.mem[st_r.rp];
    fif.head[1] = st_r.mem[st_r.rp + AW'(1)];
    fif.level = st_r.level;
    fif.space = 8'(DEPTH) - st_r.level;
  end

  // held in reset the contents are dropped and the level reads zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !fifo_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// >>> hw/ahrb_engine.sv
/*
  ahrb_engine: protocol engine; sequences setup, strobe and recovery phases of pio
  cycles and dma bursts, each phase lasting at least its timing register in clock periods.
  assumes: fifo push and pop are granted in the cycle they are raised; drive pins async.
*/
`timescale 1ns/100ps
module ahrb_engine
  import ahrb_pkg::*;
(
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic eng_rst_n,
  // configuration
  input wire ahrb_timing_t timing,
  input wire logic burst_accept,
  input wire logic ultra_sel,
  input wire logic dir_out,
  input wire logic iordy_en,
  // pio requests from same-clock logic
  input wire logic pio_start,
  input wire logic pio_write,
  input wire logic [15:0] pio_wdata,
  output logic [15:0] pio_rdata,
  output logic pio_done,
  output logic idle,
  // fifo side
  input wire logic [7:0] fifo_level,
  input wire logic [7:0] fifo_space,
  input wire logic [15:0] fifo_head,
  output logic eng_push,
  output logic eng_pop,
  output logic [15:0] eng_wdata,
  // drive pins
  input wire logic ata_dmarq,
  input wire logic ata_iordy,
  input wire logic [15:0] ata_data_in,
  output logic [15:0] ata_data_out,
  output logic ata_data_oe,
  output logic ata_dior_n,
  output logic ata_diow_n,
  output logic ata_dmack_n
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_ACTIVE, S_RECOVER} ahrb_eng_state_t;

  typedef struct packed {
    ahrb_eng_state_t st;
    logic [7:0] cnt;
    logic is_dma;
    logic is_write;
    logic ultra;
    logic [1:0] dmarq_s;
    logic [1:0] iordy_s;
    logic [15:0] din1;
    logic [15:0] din2;
    logic [15:0] hold;
    logic [15:0] dout;
    logic oe;
    logic dior_n;
    logic diow_n;
    logic dmack_n;
    logic [15:0] rdata;
    logic done;
    logic idle;
  } ahrb_eng_st_t;

  ahrb_eng_st_t st_r;
  ahrb_eng_st_t st_nxt;

  // zero is not a legal duration, treat it as one period
  function automatic logic [7:0] phase_len(input ahrb_timing_t t, input logic [1:0] ph,
                                           input logic dma, input logic ultra,
                                           input logic wr);
    logic [7:0] v;
    v = 8'h01;
    if (!dma)
      v = (ph == PH_SETUP) ? t[TP_PIO_SETUP] :
          (ph == PH_ACTIVE) ? (wr ? t[TP_PIO_WRITE] : t[TP_PIO_READ]) : t[TP_PIO_RECOVER];
    else if (!ultra)
      v = (ph == PH_SETUP) ? t[TP_MDMA_SETUP] :
          (ph == PH_ACTIVE) ? t[TP_MDMA_ACTIVE] : t[TP_MDMA_RECOVER];
    else
      v = (ph == PH_SETUP) ? t[TP_UDMA_SETUP] :
          (ph == PH_ACTIVE) ? t[TP_UDMA_ACTIVE] : t[TP_UDMA_RECOVER];
    return (v == 8'h00) ? 8'h01 : v;
  endfunction

  always_comb
  begin
    logic last;
    last = (st_r.cnt <= 8'h01);
    st_nxt = st_r;
    st_nxt.dmarq_s = {st_r.dmarq_s[0], ata_dmarq};
    st_nxt.iordy_s = {st_r.iordy_s[0], ata_iordy};
    st_nxt.din1 = ata_data_in;
    st_nxt.din2 = st_r.din1;
    st_nxt.done = 1'b0;
    eng_push = 1'b0;
    eng_pop = 1'b0;
    eng_wdata = st_r.din2;
    unique case (st_r.st)
      S_IDLE:
      begin
        if (pio_start)
        begin
          st_nxt.is_dma = 1'b0;
          st_nxt.is_write = pio_write;
          st_nxt.hold = pio_wdata;
          st_nxt.st = S_SETUP;
          st_nxt.cnt = phase_len(timing, PH_SETUP, 1'b0, 1'b0, pio_write);
        end
        else if (burst_accept && st_r.dmarq_s[1])
        begin
          st_nxt.is_dma = 1'b1;
          st_nxt.ultra = ultra_sel;
          st_nxt.is_write = dir_out;
          st_nxt.dmack_n = 1'b0;
          st_nxt.st = S_SETUP;
          st_nxt.cnt = phase_len(timing, PH_SETUP, 1'b1, ultra_sel, dir_out);
        end
      end
      S_SETUP:
      begin
        if (!last)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else if (!st_r.is_dma || (st_r.is_write ? fifo_level != 8'h00 : fifo_space != 8'h00))
        begin
          // burst data out is taken from the fifo, pio data from the held word, as the strobe opens
          if (st_r.is_write)
          begin
            st_nxt.oe = 1'b1;
            st_nxt.dout = st_r.is_dma ? fifo_head : st_r.hold;
            eng_pop = st_r.is_dma;
          end
          st_nxt.dior_n = st_r.is_write;
          st_nxt.diow_n = !st_r.is_write;
          st_nxt.st = S_ACTIVE;
          st_nxt.cnt = phase_len(timing, PH_ACTIVE, st_r.is_dma, st_r.ultra, st_r.is_write);
        end
      end
      S_ACTIVE:
      begin
        if (!last)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else if (!st_r.is_dma && iordy_en && !st_r.iordy_s[1])
          st_nxt.cnt = st_r.cnt;
        else if (!(st_r.is_dma && !st_r.is_write && fifo_space == 8'h00))
        begin
          st_nxt.dior_n = 1'b1;
          st_nxt.diow_n = 1'b1;
          if (!st_r.is_write && st_r.is_dma)
            eng_push = 1'b1;
          if (!st_r.is_write && !st_r.is_dma)
            st_nxt.rdata = st_r.din2;
          st_nxt.st = S_RECOVER;
          st_nxt.cnt = phase_len(timing, PH_RECOVER, st_r.is_dma, st_r.ultra, st_r.is_write);
        end
      end
      S_RECOVER:
      begin
        if (!last)
          st_nxt.cnt = st_r.cnt - 8'h01;
        else
        begin
          st_nxt.oe = 1'b0;
          if (st_r.is_dma && burst_accept && st_r.dmarq_s[1])
          begin
            st_nxt.st = S_SETUP;
            st_nxt.cnt = phase_len(timing, PH_SETUP, 1'b1, st_r.ultra, st_r.is_write);
          end
          else
          begin
            st_nxt.dmack_n = 1'b1;
            st_nxt.done = !st_r.is_dma;
            st_nxt.st = S_IDLE;
          end
        end
      end
    endcase
    st_nxt.idle = (st_nxt.st == S_IDLE);
  end

  // drive reset bit also clears the engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !eng_rst_n)
    begin
      st_r <= '0;
      st_r.dior_n <= 1'b1;
      st_r.diow_n <= 1'b1;
      st_r.dmack_n <= 1'b1;
      st_r.idle <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign pio_rdata = st_r.rdata;
  assign pio_done = st_r.done;
  assign idle = st_r.idle;
  assign ata_data_out = st_r.dout;
  assign ata_data_oe = st_r.oe;
  assign ata_dior_n = st_r.dior_n;
  assign ata_diow_n = st_r.diow_n;
  assign ata_dmack_n = st_r.dmack_n;
endmodule

// >>> hw/ahrb_top.sv
/*
  ahrb_top: software register block of a parallel disk host interface, axi4-lite slave.
  holds bus timing registers, the fifo data ports, fill count and control register.
  assumes: one 25 MHz clock, synchronous active-low reset; endian strap and drive pins async.
*/
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module ahrb_top
  import ahrb_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // byte order strap, high selects big endian
  input wire logic big_endian_sel,
  // system dma requests
  output logic fifo_tx_dma_req,
  output logic fifo_rx_dma_req,
  // pio requests
  input wire logic pio_start,
  input wire logic pio_write,
  input wire logic [15:0] pio_wdata,
  output logic [15:0] pio_rdata,
  output logic pio_done,
  output logic engine_idle,
  // drive pins
  output logic ata_reset_n,
  input wire logic ata_dmarq,
  input wire logic ata_iordy,
  input wire logic [15:0] ata_data_in,
  output logic [15:0] ata_data_out,
  output logic ata_data_oe,
  output logic ata_dior_n,
  output logic ata_diow_n,
  output logic ata_dmack_n
);
  typedef struct packed {
    logic [1:0] be_sync;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic aw_got;
    logic w_got;
    logic ar_got;
    logic [IDX_W-1:0] aw_idx;
    logic [IDX_W-1:0] ar_idx;
    logic aw_bad;
    logic ar_bad;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    ahrb_timing_t timing;
    logic [7:0] ctrl;
    logic [7:0] alarm;
    logic tx_req;
    logic rx_req;
  } ahrb_top_st_t;

  ahrb_top_st_t st_r;
  ahrb_top_st_t st_nxt;

  ahrb_fifo_if fif ();

  logic eng_push;
  logic eng_pop;
  logic [15:0] eng_wdata;

  // swap bytes of a halfword when big endian is selected
  function automatic logic [15:0] order_half(input logic [15:0] d, input logic be);
    return be ? {d[7:0], d[15:8]} : d;
  endfunction

  // fifo entries keep byte 0 in the low lane; only port lanes depend on byte order
  function automatic logic [1:0][15:0] word_to_fifo(input logic [31:0] d, input logic be);
    logic [1:0][15:0] e;
    e[0] = be ? order_half(d[31:16], 1'b1) : d[15:0];
    e[1] = be ? order_half(d[15:0], 1'b1) : d[31:16];
    return e;
  endfunction

  function automatic logic [31:0] fifo_to_word(input logic [1:0][15:0] e, input logic be);
    return be ? {order_half(e[0], 1'b1), order_half(e[1], 1'b1)} : {e[1], e[0]};
  endfunction

  ahrb_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .fifo_rst_n(st_r.ctrl[CTL_FIFO_RESET_N]),
    .fif(fif)
  );

  ahrb_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .eng_rst_n(st_r.ctrl[CTL_DRIVE_RESET_N]),
    .timing(st_r.timing),
    .burst_accept(st_r.ctrl[CTL_DRIVE_BURST_ACCEPT]),
    .ultra_sel(st_r.ctrl[CTL_BURST_PROTOCOL_SELECT]),
    .dir_out(st_r.ctrl[CTL_BURST_DIRECTION_OUT]),
    .iordy_en(st_r.ctrl[CTL_PIO_READY_WAIT_ENABLE]),
    .pio_start(pio_start),
    .pio_write(pio_write),
    .pio_wdata(pio_wdata),
    .pio_rdata(pio_rdata),
    .pio_done(pio_done),
    .idle(engine_idle),
    .fifo_level(fif.level),
    .fifo_space(fif.space),
    .fifo_head(fif.head[0]),
    .eng_push(eng_push),
    .eng_pop(eng_pop),
    .eng_wdata(eng_wdata),
    .ata_dmarq(ata_dmarq),
    .ata_iordy(ata_iordy),
    .ata_data_in(ata_data_in),
    .ata_data_out(ata_data_out),
    .ata_data_oe(ata_data_oe),
    .ata_dior_n(ata_dior_n),
    .ata_diow_n(ata_diow_n),
    .ata_dmack_n(ata_dmack_n)
  );

  always_comb
  begin
    logic be;
    logic eng_owns;
    logic do_wr;
    logic do_rd;
    be = st_r.be_sync[1];
    eng_owns = eng_push || eng_pop;
    do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid && !eng_owns;
    do_rd = st_r.ar_got && !st_r.rvalid && !eng_owns;
    st_nxt = st_r;
    st_nxt.be_sync = {st_r.be_sync[0], big_endian_sel};
    fif.push_n = 2'h0;
    fif.push_data = '0;
    fif.pop_n = 2'h0;

    // the engine is served first; any register access waits a cycle while it uses the fifo
    if (eng_push)
    begin
      fif.push_n = 2'h1;
      fif.push_data[0] = eng_wdata;
    end
    if (eng_pop)
      fif.pop_n = 2'h1;

    // address and data are taken independently, in either order
    if (s_axi_awvalid && st_r.aw_rdy)
    begin
      st_nxt.aw_rdy = 1'b0;
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      st_nxt.aw_bad = |s_axi_awaddr[1:0];
    end
    if (s_axi_wvalid && st_r.w_rdy)
    begin
      st_nxt.w_rdy = 1'b0;
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (s_axi_arvalid && st_r.ar_rdy)
    begin
      st_nxt.ar_rdy = 1'b0;
      st_nxt.ar_got = 1'b1;
      st_nxt.ar_idx = s_axi_araddr[ADDR_W-1:2];
      st_nxt.ar_bad = |s_axi_araddr[1:0];
    end

    // write execution
    if (do_wr)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (st_r.aw_bad)
        st_nxt.bresp = RESP_SLVERR;
      else if (st_r.aw_idx <= IDX_TIMING_LAST)
      begin
        if (st_r.wstrb[0])
          st_nxt.timing[st_r.aw_idx[4:0]] = st_r.wdata[7:0];
      end
      else if (st_r.aw_idx == IDX_FIFO_WORD)
      begin
        // a word lands whole or not at all, so the byte stream never tears
        if (st_r.wstrb == 4'hf && fif.space >= 8'h02)
        begin
          fif.push_n = 2'h2;
          fif.push_data = word_to_fifo(st_r.wdata, be);
        end
        else
          st_nxt.bresp = RESP_SLVERR;
      end
      else if (st_r.aw_idx == IDX_FIFO_HALF)
      begin
        if (st_r.wstrb[1:0] == 2'h3 && fif.space >= 8'h01)
        begin
          fif.push_n = 2'h1;
          fif.push_data[0] = order_half(st_r.wdata[15:0], be);
        end
        else
          st_nxt.bresp = RESP_SLVERR;
      end
      else if (st_r.aw_idx == IDX_FIFO_FILL)
        st_nxt.bresp = RESP_OKAY;
      else if (st_r.aw_idx == IDX_CONTROL)
      begin
        if (st_r.wstrb[0])
          st_nxt.ctrl = st_r.wdata[7:0];
      end
      else if (st_r.aw_idx == IDX_ALARM)
      begin
        if (st_r.wstrb[0])
          st_nxt.alarm = st_r.wdata[7:0];
      end
      else
        st_nxt.bresp = RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
      st_nxt.aw_rdy = 1'b1;
      st_nxt.w_rdy = 1'b1;
    end

    // read execution
    if (do_rd)
    begin
      st_nxt.ar_got = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (st_r.ar_bad)
        st_nxt.rresp = RESP_SLVERR;
      else if (st_r.ar_idx <= IDX_TIMING_LAST)
        st_nxt.rdata = {24'h00_0000, st_r.timing[st_r.ar_idx[4:0]]};
      else if (st_r.ar_idx == IDX_FIFO_WORD)
      begin
        // an empty port answers with an error rather than stale data
        if (fif.level >= 8'h02)
        begin
          fif.pop_n = 2'h2;
          st_nxt.rdata = fifo_to_word(fif.head, be);
        end
        else
          st_nxt.rresp = RESP_SLVERR;
      end
      else if (st_r.ar_idx == IDX_FIFO_HALF)
      begin
        if (fif.level >= 8'h01)
        begin
          fif.pop_n = 2'h1;
          st_nxt.rdata = {16'h0000, order_half(fif.head[0], be)};
        end
        else
          st_nxt.rresp = RESP_SLVERR;
      end
      else if (st_r.ar_idx == IDX_FIFO_FILL)
        st_nxt.rdata = {24'h00_0000, fif.level};
      else if (st_r.ar_idx == IDX_CONTROL)
        st_nxt.rdata = {24'h00_0000, st_r.ctrl};
      else if (st_r.ar_idx == IDX_ALARM)
        st_nxt.rdata = {24'h00_0000, st_r.alarm};
      else
        st_nxt.rresp = RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
      st_nxt.ar_rdy = 1'b1;
    end

    // system dma requests follow the fill level against the alarm level
    st_nxt.tx_req = st_r.ctrl[CTL_FIFO_TX_DMA_ENABLE] && (fif.level < st_r.alarm);
    st_nxt.rx_req = st_r.ctrl[CTL_FIFO_RX_DMA_ENABLE] && (fif.level >= st_r.alarm);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.aw_rdy <= 1'b1;
      st_r.w_rdy <= 1'b1;
      st_r.ar_rdy <= 1'b1;
      st_r.timing <= {TIMING_COUNT{TIMING_RST}};
      st_r.ctrl <= CONTROL_RST;
      st_r.alarm <= ALARM_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.aw_rdy;
  assign s_axi_wready = st_r.w_rdy;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_rdy;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign fifo_tx_dma_req = st_r.tx_req;
  assign fifo_rx_dma_req = st_r.rx_req;
  assign ata_reset_n = st_r.ctrl[CTL_DRIVE_RESET_N];
endmodule

// >>> verification/ahrb_checker.sv
/*
  ahrb_checker: port assertions for ahrb_top.
  assumes: bound onto ahrb_top; one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module ahrb_checker
  import ahrb_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // dma and drive side
  input wire logic fifo_tx_dma_req,
  input wire logic fifo_rx_dma_req,
  input wire logic engine_idle,
  input wire logic ata_reset_n,
  input wire logic ata_dior_n,
  input wire logic ata_diow_n,
  input wire logic ata_dmack_n
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // three cycles so the registered pin and engine state have both settled
  sequence drive_held;
    !ata_reset_n [*3];
  endsequence
  a_read_answer: assert property (ar_take |-> ##[2:20] s_axi_rvalid)
    else $error("read answer missing");
  a_ar_busy: assert property (ar_take |=> !s_axi_arready [*2])
    else $error("read address taken twice");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not released");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("refused read returned data");
  a_dma_excl: assert property (!(fifo_tx_dma_req && fifo_rx_dma_req))
    else $error("both dma requests high");
  a_strobe_excl: assert property (ata_dior_n || ata_diow_n)
    else $error("both strobes low");
  a_engine_held: assert property (drive_held |->
    engine_idle && ata_dmack_n && ata_dior_n && ata_diow_n) else $error("engine ran in reset");
endmodule
bind ahrb_top ahrb_checker chk (.*);

// >>> verification/ahrb_drive_model.sv
/*
  ahrb_drive_model: simple disk drive on the parallel bus.
  assumes: active-low strobes; the bench sets request and ready pace.
*/
`timescale 1ns/100ps
module ahrb_drive_model
(
  // clock and drive pins
  input wire logic aclk,
  input wire logic ata_reset_n,
  input wire logic ata_dior_n,
  input wire logic ata_diow_n,
  output logic ata_dmarq,
  output logic ata_iordy,
  output logic [15:0] ata_data_in,
  // bench pacing
  input wire logic want_dmarq,
  input wire logic iordy_slow
);
  logic [3:0] held = '0;
  logic [15:0] cnt = '0;
  always @(posedge aclk)
  begin
    cnt <= cnt + 16'h1;
    held <= (ata_dior_n && ata_diow_n) ? 4'h0 : held + 4'h1;
  end
  // a drive in reset never requests
  assign ata_dmarq = want_dmarq && ata_reset_n;
  // slow ready forces the host to stretch its strobe
  assign ata_iordy = !iordy_slow || held > 4'h4;
  // released bus toggles so stale data cannot pass
  assign ata_data_in = ata_dior_n ? cnt : 16'hc35a;
endmodule

// >>> verification/ahrb_tb_top.sv
/*
  ahrb_tb_top: register, fifo and drive tests of ahrb_top.
  assumes: ahrb_drive_model on the drive pins.
*/
`timescale 1ns/100ps
module ahrb_tb_top
  import ahrb_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, big_endian_sel = 1'b0, pio_start = 1'b0;
  logic pio_write = 1'b1, want_dmarq = 1'b0, iordy_slow = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic [15:0] pio_wdata = 16'h1234;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] pio_rdata, ata_data_in, ata_data_out;
  wire fifo_tx_dma_req, fifo_rx_dma_req, pio_done, engine_idle, ata_reset_n, ata_dmarq;
  wire ata_iordy, ata_data_oe, ata_dior_n, ata_diow_n, ata_dmack_n;
  int miscompares = 0, comparisons = 0, lo;
  always #20 aclk = ~aclk;
  ahrb_top dut (.*);
  ahrb_drive_model drv (.*);
  task chk(input string nm, input logic [34:0] e, input logic [34:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("write", {1'b1, RESP_OKAY}, {s_axi_bvalid, s_axi_bresp});
    // let registered side effects land before the caller looks
    repeat (2) @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("read", {1'b1, r, d}, {s_axi_rvalid, s_axi_rresp, s_axi_rdata});
  endtask
  task pio;
    @(posedge aclk);
    pio_start <= 1'b1;
    @(posedge aclk);
    pio_start <= 1'b0;
    lo = 0;
    while (!pio_done)
    begin
      @(posedge aclk);
      lo += !ata_diow_n;
    end
  endtask
  task end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 24; i++) rd(8'(i * 4), 32'h1, RESP_OKAY);
    rd(8'ha0, 32'h0, RESP_SLVERR);
    wr(8'h90, 32'hc1, 4'hf);
    chk("drive reset", 1'b1, ata_reset_n);
    wr(8'h10, 32'hffff_ffff, 4'hf);
    rd(8'h10, 32'hff, RESP_OKAY);
    wr(8'h60, 32'h4433_2211, 4'hf);
    rd(8'h80, 32'h2, RESP_OKAY);
    rd(8'h70, 32'h2211, RESP_OKAY);
    big_endian_sel <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h70, 32'h3344, RESP_OKAY);
    rd(8'h70, 32'h0, RESP_SLVERR);
    wr(8'h60, 32'haabb_ccdd, 4'hf);
    wr(8'h80, 32'h0, 4'hf);
    rd(8'h80, 32'h2, RESP_OKAY);
    big_endian_sel <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h60, 32'hddcc_bbaa, RESP_OKAY);
    wr(8'h90, 32'hf1, 4'hf);
    chk("dma req", 2'h2, {fifo_tx_dma_req, fifo_rx_dma_req});
    wr(8'hc0, 32'h1, 4'hf);
    wr(8'h70, 32'h5678, 4'h3);
    chk("dma req", 2'h1, {fifo_tx_dma_req, fifo_rx_dma_req});
    wr(8'h90, 32'h41, 4'hf);
    chk("dma req", 2'h0, {fifo_tx_dma_req, fifo_rx_dma_req});
    rd(8'h80, 32'h0, RESP_OKAY);
    wr(8'h90, 32'hc1, 4'hf);
    wr(8'h0c, 32'h3, 4'hf);
    pio;
    chk("strobe", 35'h3, lo);
    chk("pio data", 16'h1234, ata_data_out);
    iordy_slow <= 1'b1;
    pio;
    chk("ready wait", 1'b1, lo > 3);
    pio_write <= 1'b0;
    pio;
    chk("pio read", 16'hc35a, pio_rdata);
    wr(8'h2c, 32'h8, 4'hf);
    want_dmarq <= 1'b1;
    repeat (30) @(posedge aclk);
    rd(8'h80, 32'h0, RESP_OKAY);
    wr(8'h90, 32'hc9, 4'hf);
    repeat (40) @(posedge aclk);
    want_dmarq <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(8'h70, 32'hc35a, RESP_OKAY);
    wr(8'h90, 32'h41, 4'hf);
    wr(8'h90, 32'hce, 4'hf);
    wr(8'h70, 32'h9abc, 4'h3);
    want_dmarq <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("data out", 16'h9abc, ata_data_out);
    rd(8'h80, 32'h0, RESP_OKAY);
    end_sim;
  end
endmodule
